/* inc/cfps_regs.vh */
// Constants for the core fetch pipeline and shadow store
`ifndef CFPS_REGS_VH
`define CFPS_REGS_VH

// ----------------------------------------
// Program counter
// ----------------------------------------
`define CFPS_PC_W       21
`define CFPS_PC_RST     21'h000000
`define CFPS_PC_STEP    21'h000002
`define CFPS_VEC_HI     21'h000008
`define CFPS_VEC_LO     21'h000018
`define CFPS_BR_EXT     9
`define CFPS_LSB_ZERO   1'b0

// ----------------------------------------
// Phases
// ----------------------------------------
`define CFPS_PH_NONE    4'h0
`define CFPS_PH_ONE     4'h1
`define CFPS_PH_TWO     4'h2
`define CFPS_PH_THREE   4'h4
`define CFPS_PH_FOUR    4'h8

// ----------------------------------------
// Instruction classes
// ----------------------------------------
`define CFPS_CL_OTHER   4'h0
`define CFPS_CL_SECOND  4'h1
`define CFPS_CL_GOTO    4'h2
`define CFPS_CL_CALL    4'h3
`define CFPS_CL_FMOVE   4'h4
`define CFPS_CL_LFSR    4'h5
`define CFPS_CL_BRA     4'h6
`define CFPS_CL_RCALL   4'h7
`define CFPS_CL_RETFI   4'h8
`define CFPS_CL_RETURN  4'h9
`define CFPS_CL_TBLRD   4'hA

// ----------------------------------------
// Opcode masks and values
// ----------------------------------------
`define CFPS_M_SECOND   16'hF000
`define CFPS_V_SECOND   16'hF000
`define CFPS_M_GOTO     16'hFF00
`define CFPS_V_GOTO     16'hEF00
`define CFPS_M_CALL     16'hFE00
`define CFPS_V_CALL     16'hEC00
`define CFPS_M_FMOVE    16'hF000
`define CFPS_V_FMOVE    16'hC000
`define CFPS_M_LFSR     16'hFFC0
`define CFPS_V_LFSR     16'hEE00
`define CFPS_M_BRA      16'hF800
`define CFPS_V_BRA      16'hD000
`define CFPS_V_RCALL    16'hD800
`define CFPS_M_RET      16'hFFFE
`define CFPS_V_RETFI    16'h0010
`define CFPS_V_RETURN   16'h0012
`define CFPS_M_TBLRD    16'hFFFC
`define CFPS_V_TBLRD    16'h0008

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define CFPS_RET_FAST   0
`define CFPS_CALL_FAST  8
`define CFPS_LIT_MSB    11
`define CFPS_GOTO_MSB   7
`define CFPS_BR_MSB     10
`define CFPS_W_RST      16'h0000
`define CFPS_B_RST      8'h00
`define CFPS_N_RST      4'h0
`define CFPS_L_RST      12'h000

`endif

/* verilog/cfps_qclk.v */
// Four-phase instruction cycle generator
`timescale 1ns/10ps
`include "cfps_regs.vh"

module cfps_qclk (
   // Clock and reset
   input  wire clk,
   input  wire rst_n,
   // Phases
   output wire phase_one,
   output wire phase_two,
   output wire phase_three,
   output wire phase_four
);

   reg [3:0] ph;

   // ----------------------------------------
   // One-hot ring, idle slot right after reset
   // ----------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ph <= `CFPS_PH_NONE;
      end else if (ph == `CFPS_PH_NONE || ph == `CFPS_PH_FOUR) begin
         ph <= `CFPS_PH_ONE;
      end else begin
         ph <= {ph[2:0], 1'b0};
      end
   end

   assign phase_one   = ph[0];
   assign phase_two   = ph[1];
   assign phase_three = ph[2];
   assign phase_four  = ph[3];

endmodule

/* verilog/cfps_shadow.v */
// One-level shadow store for status, working register and bank pointer
`timescale 1ns/10ps
`include "cfps_regs.vh"

module cfps_shadow (
   // Clock and reset
   input  wire       clk,
   input  wire       rst_n,
   // Save request and live values
   input  wire       save,
   input  wire [7:0] status_in,
   input  wire [7:0] work_in,
   input  wire [3:0] bank_in,
   // Stored values
   output reg  [7:0] status_out,
   output reg  [7:0] work_out,
   output reg  [3:0] bank_out
);

   // ----------------------------------------
   // Storage, no software path
   // ----------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status_out <= `CFPS_B_RST;
         work_out   <= `CFPS_B_RST;
         bank_out   <= `CFPS_N_RST;
      end else if (save) begin
         status_out <= status_in;
         work_out   <= work_in;
         bank_out   <= bank_in;
      end
   end

endmodule

/* verilog/cfps_core.v */
// Fetch/execute pipeline with program counter, flush and shadow store
`timescale 1ns/10ps
`include "cfps_regs.vh"

module cfps_core (
   // Clock and reset
   input  wire        clk,
   input  wire        rst_n,
   // Program memory
   output reg  [20:0] pmem_addr,
   input  wire [15:0] pmem_rdata,
   // Datapath inputs
   input  wire        skip_req,
   input  wire        pc_low_wr,
   input  wire [7:0]  pc_low_wdata,
   input  wire [7:0]  pc_high_latch,
   input  wire [4:0]  pc_upper_latch,
   input  wire [7:0]  status_val,
   input  wire [7:0]  work_val,
   input  wire [3:0]  bank_val,
   // Table read
   input  wire [20:0] table_pointer,
   output reg  [7:0]  table_latch,
   output reg         table_done,
   // Return stack
   input  wire [20:0] ret_addr,
   output reg         push_req,
   output reg  [20:0] push_addr,
   output reg         pop_req,
   // Interrupts
   input  wire        irq_req,
   input  wire        irq_high,
   output reg         irq_ack,
   // Execute stage
   output wire        phase_one,
   output wire        phase_two,
   output wire        phase_three,
   output wire        phase_four,
   output reg  [15:0] instruction_holding_register,
   output reg         exec_valid,
   output reg         operand_rd,
   output reg         dest_wr,
   output reg  [11:0] operand_lit,
   output reg         operand_lit_valid,
   output reg  [7:0]  pc_low_byte,
   // Shadow restore
   output reg         shadow_load,
   output wire [7:0]  shadow_status,
   output wire [7:0]  shadow_work,
   output wire [3:0]  shadow_bank
);

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   function [3:0] op_class;
      input [15:0] w;
      begin
         if ((w & `CFPS_M_SECOND) == `CFPS_V_SECOND)
            op_class = `CFPS_CL_SECOND;
         else if ((w & `CFPS_M_GOTO) == `CFPS_V_GOTO)
            op_class = `CFPS_CL_GOTO;
         else if ((w & `CFPS_M_LFSR) == `CFPS_V_LFSR)
            op_class = `CFPS_CL_LFSR;
         else if ((w & `CFPS_M_CALL) == `CFPS_V_CALL)
            op_class = `CFPS_CL_CALL;
         else if ((w & `CFPS_M_FMOVE) == `CFPS_V_FMOVE)
            op_class = `CFPS_CL_FMOVE;
         else if ((w & `CFPS_M_BRA) == `CFPS_V_BRA)
            op_class = `CFPS_CL_BRA;
         else if ((w & `CFPS_M_BRA) == `CFPS_V_RCALL)
            op_class = `CFPS_CL_RCALL;
         else if ((w & `CFPS_M_RET) == `CFPS_V_RETFI)
            op_class = `CFPS_CL_RETFI;
         else if ((w & `CFPS_M_RET) == `CFPS_V_RETURN)
            op_class = `CFPS_CL_RETURN;
         else if ((w & `CFPS_M_TBLRD) == `CFPS_V_TBLRD)
            op_class = `CFPS_CL_TBLRD;
         else
            op_class = `CFPS_CL_OTHER;
      end
   endfunction

   // Word offset doubled into a byte displacement
   function [20:0] rel_target;
      input [20:0] base;
      input [10:0] off;
      begin
         rel_target = base + {{`CFPS_BR_EXT{off[`CFPS_BR_MSB]}}, off,
                              `CFPS_LSB_ZERO};
      end
   endfunction

   // ----------------------------------------
   // State
   // ----------------------------------------
   reg  [20:0] pc;
   reg  [20:0] fetch_addr;
   reg  [15:0] fetch_word;
   reg         fetch_valid;
   reg  [15:0] hold_word;
   reg         pend_first;

   wire [3:0]  cur_cls;
   wire [3:0]  hold_cls;
   wire [3:0]  fetch_cls;
   wire        exec_tblrd;

   reg  [20:0] next_pc;
   reg         next_redirect;
   reg         next_push;
   reg         next_pop;
   reg         next_save;
   reg         next_restore;
   reg         next_ack;
   reg         next_pend;
   reg         next_lit;

   assign cur_cls    = op_class(instruction_holding_register);
   assign hold_cls   = op_class(hold_word);
   assign fetch_cls  = op_class(fetch_word);
   assign exec_tblrd = exec_valid && (cur_cls == `CFPS_CL_TBLRD);

   // ----------------------------------------
   // Phase generator and shadow store
   // ----------------------------------------
   cfps_qclk u_qclk (
      .clk         (clk),
      .rst_n       (rst_n),
      .phase_one   (phase_one),
      .phase_two   (phase_two),
      .phase_three (phase_three),
      .phase_four  (phase_four)
   );

   cfps_shadow u_shadow (
      .clk        (clk),
      .rst_n      (rst_n),
      .save       (phase_four && next_save),
      .status_in  (status_val),
      .work_in    (work_val),
      .bank_in    (bank_val),
      .status_out (shadow_status),
      .work_out   (shadow_work),
      .bank_out   (shadow_bank)
   );

   // ----------------------------------------
   // End-of-cycle control decision
   // ----------------------------------------
   always @* begin
      next_pc       = pc;
      next_redirect = 1'b0;
      next_push     = 1'b0;
      next_pop      = 1'b0;
      next_save     = 1'b0;
      next_restore  = 1'b0;
      next_ack      = 1'b0;
      next_pend     = 1'b0;
      next_lit      = 1'b0;
      if (exec_valid) begin
         case (cur_cls)
            `CFPS_CL_GOTO, `CFPS_CL_CALL, `CFPS_CL_FMOVE, `CFPS_CL_LFSR: begin
               next_pend = 1'b1;
            end
            `CFPS_CL_SECOND: begin
               next_lit = 1'b1;
               if (hold_cls == `CFPS_CL_GOTO || hold_cls == `CFPS_CL_CALL) begin
                  next_redirect = 1'b1;
                  next_pc = {instruction_holding_register[`CFPS_LIT_MSB:0],
                             hold_word[`CFPS_GOTO_MSB:0],
                             `CFPS_LSB_ZERO};
               end
               if (hold_cls == `CFPS_CL_CALL) begin
                  next_push = 1'b1;
                  next_save = hold_word[`CFPS_CALL_FAST];
               end
            end
            `CFPS_CL_BRA: begin
               next_redirect = 1'b1;
               next_pc = rel_target(fetch_addr,
                                    instruction_holding_register[`CFPS_BR_MSB:0]);
            end
            `CFPS_CL_RCALL: begin
               next_redirect = 1'b1;
               next_push     = 1'b1;
               next_pc = rel_target(fetch_addr,
                                    instruction_holding_register[`CFPS_BR_MSB:0]);
            end
            `CFPS_CL_RETFI: begin
               next_redirect = 1'b1;
               next_pop      = 1'b1;
               next_pc       = ret_addr;
               next_restore  = instruction_holding_register[`CFPS_RET_FAST];
            end
            `CFPS_CL_RETURN: begin
               next_redirect = 1'b1;
               next_pop      = 1'b1;
               next_pc       = ret_addr;
               next_restore  = instruction_holding_register[`CFPS_RET_FAST];
            end
            default: begin
               next_pend = 1'b0;
            end
         endcase
      end
      // Computed jump through the low byte
      if (pc_low_wr) begin
         next_redirect = 1'b1;
         next_pc = {pc_upper_latch, pc_high_latch, pc_low_wdata[7:1],
                    `CFPS_LSB_ZERO};
      end
      // Interrupt waits while a branch or two-word pair is in flight
      if (irq_req && !next_redirect && !next_pend) begin
         next_ack      = 1'b1;
         next_redirect = 1'b1;
         next_push     = 1'b1;
         next_save     = 1'b1;
         next_pc       = irq_high ? `CFPS_VEC_HI : `CFPS_VEC_LO;
      end
   end

   // ----------------------------------------
   // Pipeline registers
   // ----------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pc                           <= `CFPS_PC_RST;
         pmem_addr                    <= `CFPS_PC_RST;
         fetch_addr                   <= `CFPS_PC_RST;
         fetch_word                   <= `CFPS_W_RST;
         fetch_valid                  <= 1'b0;
         hold_word                    <= `CFPS_W_RST;
         pend_first                   <= 1'b0;
         instruction_holding_register <= `CFPS_W_RST;
         exec_valid                   <= 1'b0;
         operand_rd                   <= 1'b0;
         dest_wr                      <= 1'b0;
         operand_lit                  <= `CFPS_L_RST;
         operand_lit_valid            <= 1'b0;
         table_latch                  <= `CFPS_B_RST;
         table_done                   <= 1'b0;
         push_req                     <= 1'b0;
         push_addr                    <= `CFPS_PC_RST;
         pop_req                      <= 1'b0;
         irq_ack                      <= 1'b0;
         shadow_load                  <= 1'b0;
         pc_low_byte                  <= `CFPS_B_RST;
      end else begin
         operand_rd        <= 1'b0;
         dest_wr           <= 1'b0;
         table_done        <= 1'b0;
         push_req          <= 1'b0;
         pop_req           <= 1'b0;
         irq_ack           <= 1'b0;
         shadow_load       <= 1'b0;
         operand_lit_valid <= 1'b0;
         pc_low_byte       <= pc[7:0];
         if (phase_one) begin
            pmem_addr  <= pc;
            fetch_addr <= pc;
            pc         <= pc + `CFPS_PC_STEP;
            instruction_holding_register <= fetch_word;
            // Lone second word or flushed word runs as a no-op
            exec_valid <= fetch_valid &&
                          !(fetch_cls == `CFPS_CL_SECOND && !pend_first);
         end
         if (phase_two) begin
            operand_rd <= exec_valid;
            if (exec_tblrd) begin
               pmem_addr <= {table_pointer[20:1], `CFPS_LSB_ZERO};
            end
         end
         if (phase_three && exec_tblrd) begin
            table_latch <= table_pointer[0] ? pmem_rdata[15:8]
                                            : pmem_rdata[7:0];
            table_done  <= 1'b1;
            pmem_addr   <= fetch_addr;
         end
         if (phase_four) begin
            fetch_word  <= pmem_rdata;
            // Drop the overlapped fetch on redirect or skip
            fetch_valid <= !(next_redirect || (skip_req && exec_valid));
            dest_wr     <= exec_valid;
            pend_first  <= next_pend;
            if (next_pend) begin
               hold_word <= instruction_holding_register;
            end
            if (next_lit) begin
               operand_lit       <= instruction_holding_register[`CFPS_LIT_MSB:0];
               operand_lit_valid <= 1'b1;
            end
            if (next_redirect) begin
               pc <= next_pc;
            end
            push_req    <= next_push;
            push_addr   <= fetch_addr;
            pop_req     <= next_pop;
            irq_ack     <= next_ack;
            shadow_load <= next_restore;
         end
      end
   end

endmodule

/* test/cfps_pmem_model.sv */
// Program memory and interrupt source model facing the fetch core
`timescale 1ns/10ps

module cfps_pmem_model (
   // Clock and reset
   input  wire        clk,
   input  wire        rst_n,
   // Fetch side
   input  wire [20:0] pmem_addr,
   output wire [15:0] pmem_rdata,
   // Interrupt side
   input  wire        irq_set,
   input  wire        irq_ack,
   output reg         irq_req
);
   reg     [15:0] mem [0:63];
   integer        i;

   // Word read, byte address aliased into a small array
   assign pmem_rdata = mem[pmem_addr[6:1]];

   // Request held until acknowledged
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         irq_req <= 1'b0;
      else if (irq_ack)
         irq_req <= 1'b0;
      else if (irq_set)
         irq_req <= 1'b1;
   end

   initial begin
      for (i = 0; i < 64; i = i + 1)
         mem[i] = 16'h0E00 + i[15:0];
      mem[0]  = 16'h0F55;
      mem[1]  = 16'h6E81;
      mem[2]  = 16'hD002;
      mem[3]  = 16'h1111;
      mem[4]  = 16'h0011;
      mem[5]  = 16'hEF10;
      mem[6]  = 16'hF000;
      mem[7]  = 16'h3333;
      mem[16] = 16'hF456;
      mem[17] = 16'hC123;
      mem[18] = 16'hF456;
      mem[19] = 16'h0008;
      mem[20] = 16'hED30;
      mem[21] = 16'hF000;
      mem[22] = 16'h4444;
      mem[48] = 16'h0013;
   end
endmodule

/* test/cfps_core_checker.sv */
// Port checker for the fetch pipeline core
`timescale 1ns/10ps

module cfps_core_checker (
   // Clock and reset
   input wire        clk,
   input wire        rst_n,
   // Fetch and latches
   input wire [20:0] pmem_addr,
   input wire        pc_low_wr,
   input wire [7:0]  pc_low_wdata,
   input wire [7:0]  pc_high_latch,
   input wire [4:0]  pc_upper_latch,
   // Live and shadow values
   input wire [7:0]  status_val,
   input wire [7:0]  work_val,
   input wire [3:0]  bank_val,
   input wire [7:0]  shadow_status,
   input wire [7:0]  shadow_work,
   input wire [3:0]  shadow_bank,
   input wire        shadow_load,
   // Execute stage
   input wire        phase_one,
   input wire        phase_two,
   input wire        phase_three,
   input wire        phase_four,
   input wire [15:0] instruction_holding_register,
   input wire        exec_valid,
   input wire        operand_rd,
   input wire        dest_wr,
   input wire        table_done,
   input wire        irq_ack
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_phase_order:
      assert property (phase_one |=> phase_two ##1 phase_three ##1 phase_four ##1 phase_one)
      else $error("phase order broken");
   a_pc_on_one:
      // Table read borrows the bus in phase three and hands it back in phase four
      assert property (($changed(pmem_addr) && !phase_three && !table_done)
         |-> $past(phase_one))
      else $error("fetch address moved outside phase one");
   a_pc_even:
      assert property (pmem_addr[0] == 1'b0)
      else $error("odd fetch address");
   a_ir_on_one:
      assert property ($changed(instruction_holding_register) |-> $past(phase_one))
      else $error("instruction latched outside phase one");
   a_read_phase:
      assert property (operand_rd |-> phase_three && exec_valid)
      else $error("operand read misplaced");
   a_write_phase:
      assert property (dest_wr |-> phase_one && $past(exec_valid))
      else $error("destination write misplaced");
   a_table_phase:
      assert property (table_done |-> phase_four)
      else $error("table read done misplaced");
   a_flush_slot:
      assert property ((irq_ack || shadow_load) |=> !exec_valid)
      else $error("fetched word not flushed");
   a_low_load:
      assert property ((pc_low_wr && phase_four) |=> ##1 pmem_addr ==
         ({$past(pc_upper_latch, 2), $past(pc_high_latch, 2), $past(pc_low_wdata, 2)}
         & 21'h1FFFFE))
      else $error("low byte write target wrong");
   a_shadow_save:
      assert property (irq_ack |=> shadow_status == $past(status_val, 2)
         && shadow_work == $past(work_val, 2) && shadow_bank == $past(bank_val, 2))
      else $error("shadow not saved on interrupt");
endmodule

bind cfps_core cfps_core_checker chk (
   .clk(clk), .rst_n(rst_n), .pmem_addr(pmem_addr), .pc_low_wr(pc_low_wr),
   .pc_low_wdata(pc_low_wdata), .pc_high_latch(pc_high_latch),
   .pc_upper_latch(pc_upper_latch),
   .status_val(status_val), .work_val(work_val), .bank_val(bank_val),
   .shadow_status(shadow_status), .shadow_work(shadow_work), .shadow_bank(shadow_bank),
   .shadow_load(shadow_load), .phase_one(phase_one), .phase_two(phase_two),
   .phase_three(phase_three), .phase_four(phase_four),
   .instruction_holding_register(instruction_holding_register), .exec_valid(exec_valid),
   .operand_rd(operand_rd), .dest_wr(dest_wr), .table_done(table_done), .irq_ack(irq_ack)
);

/* test/cfps_core_test.sv */
// Self-checking bench for the fetch pipeline core
`timescale 1ns/10ps
`include "cfps_regs.vh"

module cfps_core_test;
   reg         clk, rst_n, skip_req, pc_low_wr, irq_set, irq_high;
   reg  [7:0]  pc_low_wdata, pc_high_latch, status_val, work_val;
   reg  [4:0]  pc_upper_latch;
   reg  [3:0]  bank_val;
   reg  [20:0] table_pointer, ret_addr;
   wire [20:0] pmem_addr, push_addr;
   wire [15:0] pmem_rdata, ihr;
   wire [7:0]  table_latch, pc_low_byte, shadow_status, shadow_work;
   wire [3:0]  shadow_bank;
   wire [11:0] operand_lit;
   wire        table_done, push_req, pop_req, irq_req, irq_ack, exec_valid;
   wire        ph1, ph2, ph3, ph4, operand_rd, dest_wr, lit_valid, shadow_load;
   reg  [41:0] rows [0:17];
   reg  [41:0] r;
   integer     err_total, checks, cycles, k, n;

   cfps_core dut (
      .clk(clk), .rst_n(rst_n), .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata),
      .skip_req(skip_req), .pc_low_wr(pc_low_wr), .pc_low_wdata(pc_low_wdata),
      .pc_high_latch(pc_high_latch), .pc_upper_latch(pc_upper_latch),
      .status_val(status_val), .work_val(work_val), .bank_val(bank_val),
      .table_pointer(table_pointer), .table_latch(table_latch), .table_done(table_done),
      .ret_addr(ret_addr), .push_req(push_req), .push_addr(push_addr), .pop_req(pop_req),
      .irq_req(irq_req), .irq_high(irq_high), .irq_ack(irq_ack), .phase_one(ph1),
      .phase_two(ph2), .phase_three(ph3), .phase_four(ph4),
      .instruction_holding_register(ihr), .exec_valid(exec_valid), .operand_rd(operand_rd),
      .dest_wr(dest_wr), .operand_lit(operand_lit), .operand_lit_valid(lit_valid),
      .pc_low_byte(pc_low_byte), .shadow_load(shadow_load), .shadow_status(shadow_status),
      .shadow_work(shadow_work), .shadow_bank(shadow_bank)
   );

   cfps_pmem_model mem (
      .clk(clk), .rst_n(rst_n), .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata),
      .irq_set(irq_set), .irq_ack(irq_ack), .irq_req(irq_req)
   );

   // ----
   // Tasks
   // ----
   task cmp(input [31:0] got, input [31:0] exp);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask

   // Step to the next cycle in which one of the masked phases is high
   task wait_ph(input [3:0] m);
      integer c;
      begin
         c = 0;
         @(posedge clk); #1;
         while (({ph4, ph3, ph2, ph1} & m) == 4'h0 && c < 8) begin
            @(posedge clk); #1;
            c = c + 1;
         end
      end
   endtask

   task wait_flag(input sel);
      begin
         n = 0;
         while ((sel ? shadow_load : irq_ack) !== 1'b1 && n < 16) begin
            wait_ph(4'h1);
            n = n + 1;
         end
      end
   endtask

   task test_done;
      begin
         $display("checks %0d mismatches %0d", checks, err_total);
         if (err_total == 0 && checks > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 2000) begin
         err_total = err_total + 1;
         $display("unexpected at %0t: run too long", $time);
         test_done;
      end
   end

   // ----
   // Main sequence
   // ----
   initial begin
      {rst_n, skip_req, pc_low_wr, irq_set, irq_high, pc_low_wdata, pc_high_latch} = 0;
      {pc_upper_latch, err_total, checks, cycles} = 0;
      {status_val, work_val, bank_val} = {8'hA5, 8'h3C, 4'h9};
      table_pointer = 21'h000023;
      ret_addr = 21'h00002C;
      // Rows: flags {ack,push,pop,shadow load}, executes, word, fetch address
      rows[0]  = {4'h0, 1'b0, 16'h0000, 21'h000000};
      rows[1]  = {4'h0, 1'b1, 16'h0F55, 21'h000002};
      rows[2]  = {4'h0, 1'b1, 16'h6E81, 21'h000004};
      rows[3]  = {4'h0, 1'b1, 16'hD002, 21'h000006};
      rows[4]  = {4'h0, 1'b0, 16'h0000, 21'h00000A};
      rows[5]  = {4'h0, 1'b1, 16'hEF10, 21'h00000C};
      rows[6]  = {4'h0, 1'b1, 16'hF000, 21'h00000E};
      rows[7]  = {4'h0, 1'b0, 16'h0000, 21'h000020};
      rows[8]  = {4'h0, 1'b0, 16'h0000, 21'h000022};
      rows[9]  = {4'h0, 1'b1, 16'hC123, 21'h000024};
      rows[10] = {4'h0, 1'b1, 16'hF456, 21'h000026};
      rows[11] = {4'h0, 1'b1, 16'h0008, 21'h000028};
      rows[12] = {4'h0, 1'b1, 16'hED30, 21'h00002A};
      rows[13] = {4'h0, 1'b1, 16'hF000, 21'h00002C};
      rows[14] = {4'h4, 1'b0, 16'h0000, 21'h000060};
      rows[15] = {4'h0, 1'b1, 16'h0013, 21'h000062};
      rows[16] = {4'h3, 1'b0, 16'h0000, 21'h00002C};
      rows[17] = {4'h0, 1'b1, 16'h4444, 21'h00002E};
      repeat (3) @(posedge clk);
      #1;
      cmp({exec_valid, pmem_addr}, 22'h0);
      rst_n = 1'b1;
      for (k = 0; k < 18; k = k + 1) begin
         r = rows[k];
         wait_ph(4'h1);
         cmp({irq_ack, push_req, pop_req, shadow_load}, r[41:38]);
         if (k == 11) cmp({lit_valid, operand_lit}, 13'h1456);
         if (k == 12) cmp(table_latch, 8'hC1);
         if (k == 14) cmp(push_addr, 21'h00002C);
         if (k == 15) cmp({shadow_status, shadow_work, shadow_bank}, 20'hA53C9);
         wait_ph(4'h2);
         cmp(exec_valid, r[37]);
         cmp(pmem_addr, r[20:0]);
         cmp(pc_low_byte, r[7:0]);
         if (r[37]) cmp(ihr, r[36:21]);
      end
      $display("test program rows done");
      {status_val, work_val, bank_val, irq_set} = {8'h11, 8'h22, 4'h3, 1'b1};
      wait_ph(4'h1);
      irq_set = 1'b0;
      wait_flag(1'b0);
      wait_ph(4'h2);
      cmp(pmem_addr, `CFPS_VEC_LO);
      wait_ph(4'h4);
      cmp({shadow_status, shadow_work, shadow_bank}, 20'h11223);
      {status_val, work_val, bank_val, irq_high, irq_set} = {8'h44, 8'h55, 4'h6, 2'b11};
      ret_addr = 21'h000040;
      wait_ph(4'h1);
      irq_set = 1'b0;
      wait_flag(1'b0);
      wait_ph(4'h2);
      cmp(pmem_addr, `CFPS_VEC_HI);
      wait_ph(4'h4);
      cmp({shadow_status, shadow_work, shadow_bank}, 20'h44556);
      wait_flag(1'b1);
      cmp(pop_req, 1'b1);
      wait_ph(4'h2);
      cmp(pmem_addr, 21'h000040);
      $display("test interrupts done");
      {pc_upper_latch, pc_high_latch, pc_low_wdata} = {5'h01, 8'h12, 8'h34};
      wait_ph(4'h8);
      pc_low_wr = 1'b1;
      wait_ph(4'h1);
      pc_low_wr = 1'b0;
      wait_ph(4'h2);
      cmp({exec_valid, pmem_addr}, 22'h011234);
      wait_ph(4'h2);
      cmp(exec_valid, 1'b1);
      wait_ph(4'h8);
      skip_req = 1'b1;
      wait_ph(4'h1);
      skip_req = 1'b0;
      wait_ph(4'h2);
      cmp(exec_valid, 1'b0);
      wait_ph(4'h2);
      cmp(exec_valid, 1'b1);
      $display("test low byte write and skip done");
      rst_n = 1'b0;
      @(posedge clk); #1;
      cmp({exec_valid, pmem_addr, shadow_status}, 30'h0);
      rst_n = 1'b1;
      wait_ph(4'h2);
      cmp(exec_valid, 1'b0);
      $display("test second reset done");
      test_done;
   end
endmodule
